// ---- verilog/sdt_discovery_rom.sv ----
// Operation
// - Discovery space is fixed at build time; nothing the host does can change it.
// - Header starts at byte zero and points to each parameter table.
// - Bytes 20h to 2Fh are reserved; they read as blank.
// - Basic parameter table starts at byte 30h.
// - Parameter data ends at 7Bh; 7Ch to FFh are reserved.
// - Command 5Ah enters at zero; bytes 0-3 return 53h 46h 44h 50h.
// - Byte 04h returns minor revision 08h.
// - Byte 05h returns major revision 01h.
// - Byte 06h returns zero-based header count 01h.
// - Byte 07h returns access protocol FFh.
// - Byte 08h returns ID 00h, byte 0Fh returns ID FFh.
// - Bytes 09h and 0Ah return table revisions 07h and 01h.
// - Byte 0Bh returns table length 10h double words.
// - Bytes 0Ch-0Eh return little-endian pointer 30h, 00h, 00h.
// - Bytes 10h-13h return vendor ID, 00h, 01h, 03h.
// - Bytes 14h-16h return pointer 70h 00h 00h; 17h returns FFh.
// - Header lies below the basic parameter table.
// - Discovery reads use their own space, never the main array.
// - Command and address taken on rising clock; data shifted on falling.
// - Chip select high deselects, floats the output and ends a read.
`timescale 1ns/100ps

module sdt_discovery_rom
    import sdt_pkg::*;
#(
    parameter logic [7:0]               VENDOR_ID  = 8'hA5,  // Arbitrary value
    parameter logic [8*PARAM_BYTES-1:0] PARAM_DATA = '1
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic srst_i,
    // Serial pins from the host
    input  wire logic spi_sclk_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_si_i,
    // Serial data back to the host
    output wire logic spi_so_o,
    output wire logic spi_so_oe_n_o,
    // Activity
    output wire logic busy_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Pin sampling and edges
    logic [PIN_COUNT-1:0]   pin_raw;
    logic [SYNC_STAGES-1:0] sync_r [0:PIN_COUNT-1];
    logic [PIN_COUNT-1:0]   lvl_r;
    logic [PIN_COUNT-1:0]   lvl_d_r;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   cs_fall;
    logic                   selected;
    logic                   si_bit;

    // Read sequence
    sdt_state_t             state_r;
    sdt_state_t             state_nxt;
    logic [4:0]             bit_cnt_r;
    logic [4:0]             phase_len;
    logic                   phase_last;
    logic [23:0]            in_shift_r;
    logic [7:0]             cmd_word;

    // Byte address and output
    logic [23:0]            addr_r;
    logic [2:0]             out_bit_r;
    logic [7:0]             byte_r;
    logic                   so_r;
    logic                   so_oe_n_r;

    // Lookup path to the store
    sdt_rom_if rom_bus ();

    // Bits per phase of the read sequence
    function automatic logic [4:0] phase_bits(input sdt_state_t st);
        logic [4:0] n;
        n = 5'h00;
        case (st)
            ST_CMD:   n = CMD_BITS;
            ST_ADDR:  n = ADDR_BITS;
            ST_DUMMY: n = DUMMY_BITS;
            default:  n = 5'h00;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pin_raw[PIN_SCLK] = spi_sclk_i;
    assign pin_raw[PIN_CS_N] = spi_cs_n_i;
    assign pin_raw[PIN_SI]   = spi_si_i;

    // Three stages; a level counts once stages two and three agree
    // Only stage two reads stage one, which may go metastable
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                sync_r[g] <= {SYNC_STAGES{PIN_IDLE[g]}};
            end else begin
                sync_r[g] <= {sync_r[g][SYNC_STAGES-2:0], pin_raw[g]};
            end
        end

        // Agreement filter rejects a single-sample glitch
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                lvl_r[g] <= PIN_IDLE[g];
            end else if (sync_r[g][1] == sync_r[g][2]) begin
                lvl_r[g] <= sync_r[g][2];
            end
        end
    end

    // Previous filtered levels for edge finding
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            lvl_d_r <= PIN_IDLE;
        end else begin
            lvl_d_r <= lvl_r;
        end
    end

    // Edges of the filtered serial clock and select
    assign sclk_rise = lvl_r[PIN_SCLK] & ~lvl_d_r[PIN_SCLK];
    assign sclk_fall = ~lvl_r[PIN_SCLK] & lvl_d_r[PIN_SCLK];
    assign cs_fall   = ~lvl_r[PIN_CS_N] & lvl_d_r[PIN_CS_N];
    assign selected  = ~lvl_r[PIN_CS_N];
    assign si_bit    = lvl_r[PIN_SI];

    // ------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------
    // Last bit of the current phase gates every phase change
    assign phase_len  = phase_bits(state_r);
    assign phase_last = (bit_cnt_r == phase_len - 5'h01);
    assign cmd_word   = {in_shift_r[6:0], si_bit};

    // Next state; a select edge is needed after reset before a command
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cs_fall) begin
                    state_nxt = ST_CMD;
                end
            end

            ST_CMD: begin
                if (sclk_rise && phase_last) begin
                    // Other commands are not served here and see no data
                    if (cmd_word == CMD_READ_DISCOVERY) begin
                        state_nxt = ST_ADDR;
                    end else begin
                        state_nxt = ST_IGNORE;
                    end
                end
            end

            ST_ADDR: begin
                if (sclk_rise && phase_last) begin
                    state_nxt = ST_DUMMY;
                end
            end

            ST_DUMMY: begin
                if (sclk_rise && phase_last) begin
                    state_nxt = ST_SEND;
                end
            end

            ST_SEND:   state_nxt = ST_SEND;
            ST_IGNORE: state_nxt = ST_IGNORE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    // State register; deselect aborts any phase
    // Deselect is tested first, so no edge can start a phase unselected
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_r <= ST_IDLE;
        end else if (!selected) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bit counter within the current input phase
    // Cleared while deselected and on the select edge; a cut frame leaves no count behind
    always_ff @(posedge clock_i) begin
        if (srst_i || !selected || cs_fall) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_rise && phase_len != 5'h00) begin
            if (phase_last) begin
                bit_cnt_r <= 5'h00;
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // Command and address shifter, MSB first on rising clock
    // Dummy clocks carry no data and are not shifted in
    always_ff @(posedge clock_i) begin
        if (srst_i || cs_fall) begin
            in_shift_r <= 24'h000000;
        end else if (sclk_rise && (state_r == ST_CMD || state_r == ST_ADDR)) begin
            in_shift_r <= {in_shift_r[22:0], si_bit};
        end
    end

    // ------------------------------------------------------------
    // Byte address
    // ------------------------------------------------------------
    // Loaded after the last address bit, then stepped per byte sent
    // Wraps at 24 bits; bytes above the space read blank
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            addr_r <= 24'h000000;
        end else if (state_r == ST_ADDR && sclk_rise && phase_last) begin
            addr_r <= {in_shift_r[22:0], si_bit};
        end else if (state_r == ST_SEND && sclk_fall && out_bit_r == 3'h0) begin
            addr_r <= addr_r + 24'h000001;
        end
    end

    // Discovery store only; the main array is never on this path
    assign rom_bus.addr = addr_r;

    sdt_rom #(
        .VENDOR_ID  (VENDOR_ID),
        .PARAM_DATA (PARAM_DATA)
    ) u_sdt_rom (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .rom     (rom_bus.store)
    );

    // ------------------------------------------------------------
    // Output shifter
    // ------------------------------------------------------------
    // Bit index; the store has many clocks to settle between bytes
    always_ff @(posedge clock_i) begin
        if (srst_i || state_r != ST_SEND) begin
            out_bit_r <= MSB_BIT;
        end else if (sclk_fall) begin
            out_bit_r <= out_bit_r - 3'h1;
        end
    end

    // Capture a whole byte at its first bit so the address may move on
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            byte_r <= BYTE_BLANK;
        end else if (state_r == ST_SEND && sclk_fall && out_bit_r == MSB_BIT) begin
            byte_r <= rom_bus.data;
        end
    end

    // Data bit, shifted out on falling clock, MSB first
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            so_r <= 1'b0;
        end else if (state_r == ST_SEND && sclk_fall) begin
            if (out_bit_r == MSB_BIT) begin
                so_r <= rom_bus.data[MSB_BIT];
            end else begin
                so_r <= byte_r[out_bit_r];
            end
        end
    end

    // Drive from the first data edge until deselect
    // Waiting for a falling edge means the line never shows a stale bit
    always_ff @(posedge clock_i) begin
        if (srst_i || !selected || state_r != ST_SEND) begin
            so_oe_n_r <= 1'b1;
        end else if (sclk_fall) begin
            so_oe_n_r <= 1'b0;
        end
    end

    // Data and enable come straight from flops
    assign spi_so_o      = so_r;
    assign spi_so_oe_n_o = so_oe_n_r;
    assign busy_o        = (state_r != ST_IDLE);

endmodule

// ---- verilog/sdt_pkg.sv ----
package sdt_pkg;

    // ------------------------------------------------------------
    // Serial link framing
    // ------------------------------------------------------------
    localparam int         SYNC_STAGES        = 3;
    localparam int         PIN_COUNT          = 3;
    localparam int         PIN_SCLK           = 0;
    localparam int         PIN_CS_N           = 1;
    localparam int         PIN_SI             = 2;
    localparam logic [2:0] PIN_IDLE           = 3'h2;  // Chip select high, clock and data low
    localparam logic [7:0] CMD_READ_DISCOVERY = 8'h5A;
    localparam logic [4:0] CMD_BITS           = 5'h08;
    localparam logic [4:0] ADDR_BITS          = 5'h18;
    localparam logic [4:0] DUMMY_BITS         = 5'h08;
    localparam logic [2:0] MSB_BIT            = 3'h7;

    // ------------------------------------------------------------
    // Discovery space map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_HEADER        = 8'h00;
    localparam logic [7:0] ADDR_HDR_RSVD      = 8'h20;
    localparam logic [7:0] ADDR_PARAM         = 8'h30;
    localparam logic [7:0] ADDR_SPACE_END     = 8'h7B;
    localparam logic [7:0] ADDR_RSVD_FIRST    = 8'h7C;
    localparam logic [7:0] ADDR_RSVD_END      = 8'hFF;
    localparam int         PARAM_BYTES        = int'(ADDR_SPACE_END) - int'(ADDR_PARAM) + 1;
    localparam logic [7:0] BYTE_BLANK         = 8'hFF;

    // ------------------------------------------------------------
    // Header offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SIG_LAST       = 8'h03;
    localparam logic [7:0] OFS_REV_MINOR      = 8'h04;
    localparam logic [7:0] OFS_REV_MAJOR      = 8'h05;
    localparam logic [7:0] OFS_NUM_HDR        = 8'h06;
    localparam logic [7:0] OFS_ACCESS         = 8'h07;
    localparam logic [7:0] OFS_P0_ID_LSB      = 8'h08;
    localparam logic [7:0] OFS_P0_MINOR       = 8'h09;
    localparam logic [7:0] OFS_P0_MAJOR       = 8'h0A;
    localparam logic [7:0] OFS_P0_LEN         = 8'h0B;
    localparam logic [7:0] OFS_P0_PTR0        = 8'h0C;
    localparam logic [7:0] OFS_P0_PTR1        = 8'h0D;
    localparam logic [7:0] OFS_P0_PTR2        = 8'h0E;
    localparam logic [7:0] OFS_P0_ID_MSB      = 8'h0F;
    localparam logic [7:0] OFS_P1_ID          = 8'h10;
    localparam logic [7:0] OFS_P1_MINOR       = 8'h11;
    localparam logic [7:0] OFS_P1_MAJOR       = 8'h12;
    localparam logic [7:0] OFS_P1_LEN         = 8'h13;
    localparam logic [7:0] OFS_P1_PTR0        = 8'h14;
    localparam logic [7:0] OFS_P1_PTR1        = 8'h15;
    localparam logic [7:0] OFS_P1_PTR2        = 8'h16;
    localparam logic [7:0] OFS_P1_UNUSED      = 8'h17;

    // ------------------------------------------------------------
    // Header contents
    // ------------------------------------------------------------
    localparam logic [31:0] SIGNATURE         = 32'h53464450;  // "S" "F" "D" "P"
    localparam logic [7:0]  VAL_REV_MINOR     = 8'h08;
    localparam logic [7:0]  VAL_REV_MAJOR     = 8'h01;
    localparam logic [7:0]  VAL_NUM_HDR       = 8'h01;
    localparam logic [7:0]  VAL_ACCESS        = 8'hFF;
    localparam logic [7:0]  VAL_P0_ID_LSB     = 8'h00;
    localparam logic [7:0]  VAL_P0_MINOR      = 8'h07;
    localparam logic [7:0]  VAL_P0_MAJOR      = 8'h01;
    localparam logic [7:0]  VAL_P0_LEN        = 8'h10;
    localparam logic [23:0] VAL_P0_PTR        = 24'h000030;
    localparam logic [7:0]  VAL_P0_ID_MSB     = 8'hFF;
    localparam logic [7:0]  VAL_P1_MINOR      = 8'h00;
    localparam logic [7:0]  VAL_P1_MAJOR      = 8'h01;
    localparam logic [7:0]  VAL_P1_LEN        = 8'h03;
    localparam logic [23:0] VAL_P1_PTR        = 24'h000070;
    localparam logic [7:0]  VAL_P1_UNUSED     = 8'hFF;

    // ------------------------------------------------------------
    // Transaction states, Gray coded along the read path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_CMD    = 3'h1,
        ST_ADDR   = 3'h3,
        ST_DUMMY  = 3'h2,
        ST_SEND   = 3'h6,
        ST_IGNORE = 3'h7
    } sdt_state_t;

endpackage

// ---- verilog/sdt_rom_if.sv ----
`timescale 1ns/100ps

// ------------------------------------------------------------
// Byte lookup between serial engine and discovery store
// ------------------------------------------------------------
interface sdt_rom_if;
    logic [23:0] addr;
    logic [7:0]  data;

    modport reader (output addr, input data);
    modport store  (input addr, output data);
endinterface

// ---- verilog/sdt_rom.sv ----
`timescale 1ns/100ps

module sdt_rom
    import sdt_pkg::*;
#(
    parameter logic [7:0]               VENDOR_ID  = 8'hA5,  // Arbitrary value
    parameter logic [8*PARAM_BYTES-1:0] PARAM_DATA = '1
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic srst_i,
    // Lookup port
    sdt_rom_if.store  rom
);

    // ------------------------------------------------------------
    // Parameter table bytes, first byte at the table base
    // ------------------------------------------------------------
    logic [7:0] param_mem [0:PARAM_BYTES-1];
    logic [7:0] rel_ofs;

    // Fixed at build time; no write path exists at all
    for (genvar g = 0; g < PARAM_BYTES; g++) begin : g_param
        assign param_mem[g] = PARAM_DATA[8*g +: 8];
    end

    assign rel_ofs = rom.addr[7:0] - ADDR_PARAM;

    // Header image, decoded by offset
    function automatic logic [7:0] hdr_byte(input logic [7:0] ofs);
        logic [7:0] b;
        b = BYTE_BLANK;
        case (ofs)
            OFS_REV_MINOR: b = VAL_REV_MINOR;
            OFS_REV_MAJOR: b = VAL_REV_MAJOR;
            OFS_NUM_HDR:   b = VAL_NUM_HDR;
            OFS_ACCESS:    b = VAL_ACCESS;
            OFS_P0_ID_LSB: b = VAL_P0_ID_LSB;
            OFS_P0_ID_MSB: b = VAL_P0_ID_MSB;
            OFS_P0_MINOR:  b = VAL_P0_MINOR;
            OFS_P0_MAJOR:  b = VAL_P0_MAJOR;
            OFS_P0_LEN:    b = VAL_P0_LEN;
            OFS_P0_PTR0:   b = VAL_P0_PTR[7:0];
            OFS_P0_PTR1:   b = VAL_P0_PTR[15:8];
            OFS_P0_PTR2:   b = VAL_P0_PTR[23:16];
            OFS_P1_ID:     b = VENDOR_ID;
            OFS_P1_MINOR:  b = VAL_P1_MINOR;
            OFS_P1_MAJOR:  b = VAL_P1_MAJOR;
            OFS_P1_LEN:    b = VAL_P1_LEN;
            OFS_P1_PTR0:   b = VAL_P1_PTR[7:0];
            OFS_P1_PTR1:   b = VAL_P1_PTR[15:8];
            OFS_P1_PTR2:   b = VAL_P1_PTR[23:16];
            OFS_P1_UNUSED: b = VAL_P1_UNUSED;
            default: begin
                if (ofs <= OFS_SIG_LAST) begin
                    b = SIGNATURE[8*(3-ofs[1:0]) +: 8];
                end
            end
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------
    // Registered lookup; header sits below the table
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rom.data <= BYTE_BLANK;
        end else if (rom.addr[23:8] != 16'h0000) begin
            rom.data <= BYTE_BLANK;
        end else if (rom.addr[7:0] < ADDR_HDR_RSVD) begin
            rom.data <= hdr_byte(rom.addr[7:0]);
        end else if (rom.addr[7:0] < ADDR_PARAM) begin
            rom.data <= BYTE_BLANK;
        end else if (rom.addr[7:0] <= ADDR_SPACE_END) begin
            rom.data <= param_mem[rel_ofs[6:0]];
        end else begin
            rom.data <= BYTE_BLANK;
        end
    end

endmodule

// ---- tb/sdt_discovery_rom_sva.sv ----
`timescale 1ns/100ps

module sdt_discovery_rom_sva
    import sdt_pkg::*;
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic srst_i,
    // Serial pins
    input  wire logic spi_sclk_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_si_i,
    input  wire logic spi_so_o,
    input  wire logic spi_so_oe_n_o,
    input  wire logic busy_o
);

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [8:0] sel_cnt_r;

    // Cycles spent selected; saturates so a long read never wraps under the bound
    always_ff @(posedge clock_i) begin
        if (srst_i || spi_cs_n_i) begin
            sel_cnt_r <= 9'h000;
        end else if (sel_cnt_r != 9'h1FF) begin
            sel_cnt_r <= sel_cnt_r + 9'h001;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Reset itself must leave the line released, so it is not disabled by reset
    chk_reset_quiet: assert property (disable iff (1'b0)
        srst_i |=> spi_so_oe_n_o && !busy_o && !spi_so_o)
        else $error("outputs not quiet after reset");
    chk_float_deselect: assert property (
        spi_cs_n_i [*8] |-> spi_so_oe_n_o)
        else $error("output driven while deselected");
    chk_idle_deselect: assert property (
        spi_cs_n_i [*8] |-> !busy_o)
        else $error("busy while deselected");
    chk_idle_no_drive: assert property (
        !busy_o [*2] |-> spi_so_oe_n_o)
        else $error("output driven while idle");
    chk_drive_busy: assert property (
        $fell(spi_so_oe_n_o) |-> busy_o)
        else $error("output enabled outside a transaction");
    // Forty rising edges at eight cycles a period cannot pass in under 300 cycles
    chk_drive_after_hdr: assert property (
        $fell(spi_so_oe_n_o) |-> sel_cnt_r >= 9'h12C)
        else $error("output enabled before command, address and dummy");
    chk_select_wakes: assert property (
        $fell(spi_cs_n_i) |-> ##[1:8] busy_o)
        else $error("select did not start a transaction");
    chk_so_steady: assert property (
        !spi_so_oe_n_o && $rose(spi_sclk_i) |-> ##2 ($stable(spi_so_o) || spi_so_oe_n_o) [*5])
        else $error("data moved while the host samples");

endmodule

bind sdt_discovery_rom sdt_discovery_rom_sva u_sdt_discovery_rom_sva (
    .clock_i       (clock_i),
    .srst_i        (srst_i),
    .spi_sclk_i    (spi_sclk_i),
    .spi_cs_n_i    (spi_cs_n_i),
    .spi_si_i      (spi_si_i),
    .spi_so_o      (spi_so_o),
    .spi_so_oe_n_o (spi_so_oe_n_o),
    .busy_o        (busy_o)
);

// ---- tb/sdt_host_model.sv ----
`timescale 1ns/100ps

module sdt_host_model
    import sdt_pkg::*;
(
    // Clock
    input  wire logic clock_i,
    // Pins to the device
    output logic      spi_sclk_o,
    output logic      spi_cs_n_o,
    output logic      spi_si_o,
    // Data back from the device
    input  wire logic spi_so_i,
    input  wire logic spi_so_oe_n_i
);

    logic [7:0] rx [0:511];  // Bytes gathered in the last frame
    logic       quiet;       // Device stayed off the line in header bits
    logic       drove;       // Device drove every data bit

    // Serial clock stands still low between frames
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_si_o   = 1'b0;
    end

    // One bit: data set on the falling side, sampled late in the high phase
    // since the device answer lags each falling edge by several cycles
    task automatic bit_cycle(input logic b, input int half, output logic s);
        spi_sclk_o <= 1'b0;
        spi_si_o   <= b;
        repeat (half) @(posedge clock_i);
        spi_sclk_o <= 1'b1;
        repeat (half) @(posedge clock_i);
        s = spi_so_oe_n_i ? ~spi_so_i : spi_so_i;
    endtask

    // Command, address, dummy, then data bits; half sets slow or fast clock
    task automatic frame(input logic [7:0] cmd, input logic [23:0] adr,
                         input int hbits, input int obits, input int half);
        logic [39:0] hdr;
        logic        s;
        hdr        = {cmd, adr, 8'hA5 ^ adr[7:0]};
        quiet      = 1'b1;
        drove      = 1'b1;
        spi_cs_n_o <= 1'b0;
        repeat (half) @(posedge clock_i);
        for (int i = 0; i < hbits + obits; i++) begin
            bit_cycle(hdr[39], half, s);
            hdr = {hdr[38:0], ~hdr[0]};  // Noise once the header is out
            if (i < hbits) begin
                quiet &= spi_so_oe_n_i;
            end else begin
                drove &= ~spi_so_oe_n_i;
                rx[(i - hbits) / 8] = {rx[(i - hbits) / 8][6:0], s};
            end
        end
        spi_sclk_o <= 1'b0;
        repeat (half) @(posedge clock_i);
        spi_cs_n_o <= 1'b1;
        spi_si_o   <= ~spi_si_o;  // Released line must not keep its value
        repeat (8) @(posedge clock_i);
    endtask

endmodule

// ---- tb/sdt_discovery_rom_test.sv ----
`timescale 1ns/100ps

module sdt_discovery_rom_test
    import sdt_pkg::*;
;

    // ------------------------------------------------------------
    // Expected contents
    // ------------------------------------------------------------
    localparam logic [7:0] VEND = 8'h3C;  // Arbitrary identifier value

    function automatic logic [8*PARAM_BYTES-1:0] mk_param();
        logic [8*PARAM_BYTES-1:0] v;
        for (int i = 0; i < PARAM_BYTES; i++) v[8*i +: 8] = 8'(i * 37 + 11);
        return v;
    endfunction

    localparam logic [8*PARAM_BYTES-1:0] PDATA = mk_param();
    localparam logic [191:0] HDR = {8'hFF, 8'h00, 8'h00, 8'h70, 8'h03, 8'h01, 8'h00, VEND,
                                    8'hFF, 8'h00, 8'h00, 8'h30, 8'h10, 8'h01, 8'h07, 8'h00,
                                    8'hFF, 8'h01, 8'h01, 8'h08, 8'h50, 8'h44, 8'h46, 8'h53};

    logic        clock_i;
    logic        srst_i;
    logic        sclk;
    logic        cs_n;
    logic        si;
    logic        so;
    logic        so_oe_n;
    logic        busy;
    logic [31:0] rnd;
    logic [23:0] a;
    logic [7:0]  bad [4] = '{8'h02, 8'h03, 8'h0B, 8'h5B};
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;
    int          seed;

    sdt_discovery_rom #(.VENDOR_ID(VEND), .PARAM_DATA(PDATA)) u_sdt_discovery_rom (
        .clock_i       (clock_i),
        .srst_i        (srst_i),
        .spi_sclk_i    (sclk),
        .spi_cs_n_i    (cs_n),
        .spi_si_i      (si),
        .spi_so_o      (so),
        .spi_so_oe_n_o (so_oe_n),
        .busy_o        (busy)
    );

    sdt_host_model u_sdt_host_model (
        .clock_i       (clock_i),
        .spi_sclk_o    (sclk),
        .spi_cs_n_o    (cs_n),
        .spi_si_o      (si),
        .spi_so_i      (so),
        .spi_so_oe_n_i (so_oe_n)
    );

    // Reserved, undefined and out-of-space bytes all read blank
    function automatic logic [7:0] exp_byte(input logic [23:0] ad);
        if (ad[23:8] != 16'h0000) return 8'hFF;
        if (ad[7:0] < 8'h18) return HDR[8*ad[7:0] +: 8];
        if (ad[7:0] >= 8'h30 && ad[7:0] <= 8'h7B) return PDATA[8*(ad[7:0]-8'h30) +: 8];
        return 8'hFF;
    endfunction

    // ------------------------------------------------------------
    // Checking and frame tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic run(input logic [7:0] cmd, input logic [23:0] ad, input int hb,
                       input int ob, input int half);
        u_sdt_host_model.frame(cmd, ad, hb, ob, half);
        check("idle drive", {7'h00, so_oe_n}, 8'h01);
        check("idle busy", {7'h00, busy}, 8'h00);
    endtask

    // Tail bits end the frame inside a byte, which must be dropped cleanly
    task automatic read_cmp(input logic [23:0] ad, input int nb, input int tail, input int half);
        run(8'h5A, ad, 40, 8 * nb + tail, half);
        check("header quiet", {7'h00, u_sdt_host_model.quiet}, 8'h01);
        check("data driven", {7'h00, u_sdt_host_model.drove}, 8'h01);
        for (int i = 0; i < nb; i++) begin
            check("byte", u_sdt_host_model.rx[i], exp_byte(ad + 24'(i)));
        end
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Ceiling well above the roughly 35000 cycles the sequence needs
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        seed   = 32'h2512;
        srst_i = 1'b1;
        repeat (16) @(posedge clock_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        read_cmp(24'h000000, 260, 0, 4);
        // Follow the first header to the basic table, as a host would
        a = {u_sdt_host_model.rx[14], u_sdt_host_model.rx[13], u_sdt_host_model.rx[12]};
        read_cmp(a, 4 * int'(u_sdt_host_model.rx[11]), 0, 4);
        // Abort inside the address, then a clean read of the second header
        run(8'h5A, 24'h000010, 20, 0, 4);
        read_cmp(24'h000010, 8, 0, 4);
        // Random starts, lengths and aborts
        for (int k = 0; k < 14; k++) begin
            rnd = $random(seed);
            a   = rnd[23:0];
            if (rnd[24]) a[23:8] = 16'h0000;
            read_cmp(a, 1 + int'(rnd[27:25]), int'(rnd[30:28]), 4);
        end
        // Other commands are ignored and change nothing
        foreach (bad[j]) begin
            run(bad[j], 24'h000000, 56, 0, 4);
            check("refused quiet", {7'h00, u_sdt_host_model.quiet}, 8'h01);
        end
        read_cmp(24'h000000, 24, 0, 4);
        close_out();
    end

endmodule
